// ### shared/rss_pkg.sv
// shared constants of the sine synthesis sequencer and its host link
package rss_pkg;
  // clock and sample timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ;
  // routing hold window, longest time so rounded down
  localparam int ROUTE_GAP_NS = 4000;
  localparam int ROUTE_GAP_CYC = ROUTE_GAP_NS / CLK_PERIOD_NS;
  localparam int HOST_GAP_CYC = ROUTE_GAP_CYC + 16;
  // link clock made by the host
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [5:0] PH_FIRST_RISE = 6'h04;
  localparam logic [5:0] PH_END = 6'h24;
  // ramp steps
  localparam int RAMP_SHORT_MS = 32;
  localparam int RAMP_LONG_MS = 256;
  localparam int RAMP_SHORT_SMP = RAMP_SHORT_MS * SAMPLE_RATE_HZ / 1000;
  localparam int RAMP_LONG_SMP = RAMP_LONG_MS * SAMPLE_RATE_HZ / 1000;
  localparam logic [3:0] RAMP_SHORT_MAX = 4'h8;
  localparam logic [15:0] RAMP_LONG_BASE = 16'h0007;
  // frequency step in millihertz on a 24-bit phase
  localparam longint FREQ_STEP_MHZ = 3900;
  localparam logic [23:0] PHASE_STEP =
    24'((FREQ_STEP_MHZ << 24) / (longint'(SAMPLE_RATE_HZ) * 1000));
  localparam logic [11:0] AMP_FULL_CODE = 12'hfff;
  localparam int AMP_FULL_VOLTS = 120;
  localparam logic [11:0] STOP_STEP = 12'h010;
  // storage
  localparam int RAM_WORDS = 1024;
  localparam int SEQ_SLOTS = 15;
  localparam logic [3:0] SEQ_LAST = 4'he;
  localparam logic [10:0] SLICE_WORDS = 11'h003;
  // interpreter commands
  localparam logic [15:0] CMD_SYNTH_WRITE = 16'h0001;
  localparam logic [15:0] CMD_SEQUENCE = 16'h0002;
  localparam logic [15:0] CMD_START_STOP = 16'h0012;
  localparam logic [15:0] CMD_BURST_WRITE = 16'h0014;
  // main register map, address in word bits 15:12
  localparam logic [3:0] MAP_CONFIG = 4'h5;
  localparam logic [3:0] MAP_SOURCE = 4'h8;
  localparam logic [3:0] MAP_READBACK = 4'h9;
  localparam int OE_BIT = 4;
  localparam int ROUTE_BIT = 2;
  localparam int SRC_LSB = 0;
  localparam int RB_LSB = 7;
  localparam logic [1:0] SRC_SYNTH = 2'h3;
  localparam logic ROUTE_ON = 1'b1;
  localparam logic [4:0] RB_CONDITION = 5'h0c;
  // start/stop word fields
  localparam int SS_START_LSB = 8;
  localparam int SS_END_LSB = 12;
  // chip condition word bits
  localparam int COND_DRAINED_BIT = 11;
  localparam int COND_PLAYING_BIT = 10;
  localparam int COND_ROUTE_BIT = 9;
  // slice word fields
  localparam int CYC_LSB = 8;
  localparam int RISE_LSB = 4;
  // half raised-cosine, 16 steps
  localparam logic [7:0] SINE_LUT [16] = '{8'h00, 8'h02, 8'h0a, 8'h15, 8'h25, 8'h39,
    8'h4f, 8'h67, 8'h80, 8'h98, 8'hb0, 8'hc6, 8'hda, 8'hea, 8'hf5, 8'hfd};
  // host apb registers
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam int TX_MAIN_BIT = 16;
endpackage

// ### shared/rss_link_if.sv
// serial link between the host controller and the synthesis device
`timescale 1ns/10ps
`default_nettype none
interface rss_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev (input cs_b, input sclk, input mosi, output miso);
  modport host (output cs_b, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

// ### rtl/rss_host.sv
// host end: apb command port driving the serial link
`timescale 1ns/10ps
`default_nettype none
module rss_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  rss_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_SHIFT} rss_hst_e;
  localparam logic [7:0] HGAP = 8'(rss_pkg::HOST_GAP_CYC);
  localparam logic [2:0] HALF_LAST = 3'(rss_pkg::SCLK_HALF_CYC - 1);

  rss_hst_e hst_q;
  logic busy_q, main_q, cs_b_q, sclk_q, mosi_q;
  logic [15:0] word_q, rx_q;
  logic [1:0] miso_s_q;
  logic [5:0] ph_q, ph_n;
  logic [2:0] hdiv_q;
  logic [7:0] gap_q;
  logic access, tx_take, mapped;

  assign link.cs_b = cs_b_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
  assign access = psel & penable & ~pready;
  assign mapped = paddr == rss_pkg::REG_TX || paddr == rss_pkg::REG_STATUS ||
    paddr == rss_pkg::REG_RX;
  // write lands only at the edge that sees pready high
  assign tx_take = psel & penable & pready & pwrite & ~pslverr & (paddr == rss_pkg::REG_TX);
  assign ph_n = ph_q + 6'h01;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access;
      pslverr <= access & (~mapped | (pwrite & (paddr != rss_pkg::REG_TX | busy_q)));
      if (access)
      begin
        unique case (paddr)
          rss_pkg::REG_STATUS: prdata <= {31'h0, busy_q};
          rss_pkg::REG_RX: prdata <= {16'h0, rx_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      miso_s_q <= 2'h0;
    else
      miso_s_q <= {miso_s_q[0], link.miso};
  end

  // idle time since the last frame, for returning to the main map
  always_ff @(posedge clk)
  begin
    if (!rst_b || !cs_b_q)
      gap_q <= 8'h0;
    else if (gap_q != HGAP)
      gap_q <= gap_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hst_q <= H_IDLE;
      busy_q <= 1'b0;
      main_q <= 1'b0;
      word_q <= 16'h0;
      rx_q <= 16'h0;
      ph_q <= 6'h0;
      hdiv_q <= 3'h0;
      cs_b_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      unique case (hst_q)
        H_IDLE:
        begin
          if (tx_take)
          begin
            word_q <= pwdata[15:0];
            main_q <= pwdata[rss_pkg::TX_MAIN_BIT];
            busy_q <= 1'b1;
            hst_q <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          // main-map word waits out the window
          if (!main_q || gap_q == HGAP)
          begin
            cs_b_q <= 1'b0;
            mosi_q <= word_q[15];
            ph_q <= 6'h0;
            hdiv_q <= 3'h0;
            hst_q <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          hdiv_q <= (hdiv_q == HALF_LAST) ? 3'h0 : hdiv_q + 3'h1;
          if (hdiv_q == HALF_LAST)
          begin
            ph_q <= ph_n;
            if (ph_n == rss_pkg::PH_END)
            begin
              cs_b_q <= 1'b1;
              busy_q <= 1'b0;
              hst_q <= H_IDLE;
            end
            else if (ph_n >= rss_pkg::PH_FIRST_RISE && !ph_n[0])
            begin
              sclk_q <= 1'b1;
              rx_q <= {rx_q[14:0], miso_s_q[1]};
            end
            else if (ph_n > rss_pkg::PH_FIRST_RISE)
            begin
              sclk_q <= 1'b0;
              word_q <= {word_q[14:0], 1'b0};
              mosi_q <= word_q[14];
            end
          end
        end
        default: hst_q <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/rss_dev.sv
// device end: command interpreter, sine synthesis sequencer and sample output
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - source select 3 means synthesis parameters
// - ram is 1024 words of 16 bits
// - slice: amplitude, cycles/frequency, ramp codes
// - amplitude code maps linearly, full = 120 V
// - slice plays rise, sine periods, fall
// - ramp codes: none, 32 ms, 256 ms steps
// - wave: first word, last word, repeat count
// - wave repeats count times, zero plays once
// - host keeps slices of a wave contiguous
// - fifteen slots of 10-bit wave addresses
// - host writes all fifteen slots at once
// - play slots start through end inclusive
// - start/stop rewritten before every replay
// - route bit sends words to interpreter
// - route drops after a 4 us gap
// - burst ram write also accepted
// - readback selector 0xc returns condition word
// - output drive starts, drained flag ends
// - drive cleared mid-play ramps down to zero
module rss_dev #(
  parameter int SAMPLE_DIV = rss_pkg::SAMPLE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  rss_link_if.dev link,
  // sample stream to the power stage
  output logic [11:0] sample_q,
  output logic sample_tick_q,
  // playback state
  output logic playing_q,
  output logic drained_q
);
  typedef enum logic [2:0] {I_CMD, I_ADDR, I_COUNT, I_DATA, I_SEQ, I_SS} rss_intp_e;
  typedef enum logic [2:0] {P_IDLE, P_WAVE, P_SLICE, P_RISE, P_SINE, P_FALL, P_STOP,
    P_DONE} rss_play_e;
  localparam logic [7:0] GAP_CYC = 8'(rss_pkg::ROUTE_GAP_CYC);
  localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

  function automatic logic [15:0] ramp_len(input logic [3:0] code);
    logic [15:0] n;
    n = 16'(code);
    // short steps up to code 8, long beyond
    if (code <= rss_pkg::RAMP_SHORT_MAX)
      ramp_len = 16'(n * rss_pkg::RAMP_SHORT_SMP);
    else
      ramp_len = 16'((n - rss_pkg::RAMP_LONG_BASE) * rss_pkg::RAMP_LONG_SMP);
  endfunction

  // link receive
  logic [1:0] cs_s_q, sclk_s_q, mosi_s_q;
  logic cs_d_q, sclk_d_q, frame, cs_fall, sclk_rise;
  logic [3:0] bit_cnt_q;
  logic [15:0] rx_q, tx_q, word_q, cond;
  logic word_vld_q, sdo_q;
  logic [7:0] gap_q;
  logic gap_expire;
  // main map
  logic [1:0] src_q;
  logic route_q, oe_q, oe_d_q;
  logic [4:0] rb_q;
  // interpreter and storage
  rss_intp_e ist_q;
  logic burst_q, arm_q;
  logic [9:0] waddr_q;
  logic [10:0] left_q;
  logic [3:0] slot_q, ss_start_q, ss_end_q;
  logic [15:0] ram_q [rss_pkg::RAM_WORDS];
  logic [9:0] seq_tab_q [rss_pkg::SEQ_SLOTS];
  // engine
  rss_play_e pst_q;
  logic [15:0] div_q, rep_left_q, ramp_len_q, ramp_cnt_q;
  logic [3:0] seq_idx_q, fall_q;
  logic [9:0] wave_start_q, wave_end_q, slice_ptr_q, wa;
  logic [11:0] amp_q, env, sample_d;
  logic [7:0] cyc_left_q, freq_q, sine;
  logic [23:0] phase_q, phase_n;
  logic [27:0] scaled;
  logic [19:0] prod;
  logic wrap, tick, start_go, active, last_slice;

  assign frame = ~cs_s_q[1];
  assign cs_fall = cs_d_q & ~cs_s_q[1];
  assign sclk_rise = frame & sclk_s_q[1] & ~sclk_d_q;
  assign link.miso = sdo_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cs_s_q <= 2'h3;
      sclk_s_q <= 2'h0;
      mosi_s_q <= 2'h0;
      cs_d_q <= 1'b1;
      sclk_d_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[0], link.cs_b};
      sclk_s_q <= {sclk_s_q[0], link.sclk};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      cs_d_q <= cs_s_q[1];
      sclk_d_q <= sclk_s_q[1];
    end
  end

  always_comb
  begin
    cond = 16'h0;
    cond[rss_pkg::COND_DRAINED_BIT] = drained_q;
    cond[rss_pkg::COND_PLAYING_BIT] = playing_q;
    cond[rss_pkg::COND_ROUTE_BIT] = route_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      bit_cnt_q <= 4'h0;
      rx_q <= 16'h0;
      tx_q <= 16'h0;
      sdo_q <= 1'b0;
      word_q <= 16'h0;
      word_vld_q <= 1'b0;
    end
    else
    begin
      sdo_q <= tx_q[15];
      word_vld_q <= sclk_rise && bit_cnt_q == 4'hf;
      if (cs_fall)
      begin
        bit_cnt_q <= 4'h0;
        // condition word shifted out when selected
        tx_q <= (rb_q == rss_pkg::RB_CONDITION) ? cond : 16'h0;
      end
      else if (sclk_rise)
      begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        rx_q <= {rx_q[14:0], mosi_s_q[1]};
        tx_q <= {tx_q[14:0], 1'b0};
        word_q <= {rx_q[14:0], mosi_s_q[1]};
      end
    end
  end

  // idle time since the last frame
  always_ff @(posedge clk)
  begin
    if (!rst_b || frame)
      gap_q <= 8'h0;
    else if (gap_q != GAP_CYC)
      gap_q <= gap_q + 8'h01;
  end
  assign gap_expire = !frame && gap_q == GAP_CYC - 8'h01;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      src_q <= 2'h0;
      route_q <= 1'b0;
      oe_q <= 1'b0;
      rb_q <= 5'h0;
    end
    else
    begin
      if (gap_expire)
        route_q <= 1'b0;
      if (word_vld_q && !route_q)
      begin
        unique case (word_q[15:12])
          rss_pkg::MAP_SOURCE:
          begin
            src_q <= word_q[rss_pkg::SRC_LSB +: 2];
            // route later words to the interpreter
            route_q <= word_q[rss_pkg::ROUTE_BIT] == rss_pkg::ROUTE_ON;
          end
          rss_pkg::MAP_CONFIG: oe_q <= word_q[rss_pkg::OE_BIT];
          rss_pkg::MAP_READBACK: rb_q <= word_q[rss_pkg::RB_LSB +: 5];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ist_q <= I_CMD;
      burst_q <= 1'b0;
      waddr_q <= 10'h0;
      left_q <= 11'h0;
      slot_q <= 4'h0;
      ss_start_q <= 4'h0;
      ss_end_q <= 4'h0;
      arm_q <= 1'b0;
    end
    else
    begin
      if (start_go)
        arm_q <= 1'b0;
      if (!route_q)
        ist_q <= I_CMD;
      else if (word_vld_q)
      begin
        unique case (ist_q)
          I_CMD:
          begin
            slot_q <= 4'h0;
            // burst write shares the data path
            burst_q <= word_q == rss_pkg::CMD_BURST_WRITE;
            if (word_q == rss_pkg::CMD_SYNTH_WRITE || word_q == rss_pkg::CMD_BURST_WRITE)
              ist_q <= I_ADDR;
            else if (word_q == rss_pkg::CMD_SEQUENCE)
              ist_q <= I_SEQ;
            else if (word_q == rss_pkg::CMD_START_STOP)
              ist_q <= I_SS;
          end
          I_ADDR:
          begin
            waddr_q <= word_q[9:0];
            left_q <= rss_pkg::SLICE_WORDS;
            ist_q <= burst_q ? I_COUNT : I_DATA;
          end
          I_COUNT:
          begin
            left_q <= word_q[10:0];
            ist_q <= (word_q[10:0] == 11'h0) ? I_CMD : I_DATA;
          end
          I_DATA:
          begin
            ram_q[waddr_q] <= word_q;
            waddr_q <= waddr_q + 10'h1;
            left_q <= left_q - 11'h1;
            if (left_q == 11'h1)
              ist_q <= I_CMD;
          end
          I_SEQ:
          begin
            seq_tab_q[slot_q] <= word_q[9:0];
            slot_q <= slot_q + 4'h1;
            if (slot_q == rss_pkg::SEQ_LAST)
              ist_q <= I_CMD;
          end
          I_SS:
          begin
            ss_start_q <= word_q[rss_pkg::SS_START_LSB +: 4];
            ss_end_q <= word_q[rss_pkg::SS_END_LSB +: 4];
            arm_q <= 1'b1;
            ist_q <= I_CMD;
          end
          default: ist_q <= I_CMD;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || tick)
      div_q <= 16'h0;
    else
      div_q <= div_q + 16'h1;
  end
  assign tick = div_q == DIV_LAST;

  // only synthesis source starts the engine
  assign start_go = oe_q && !oe_d_q && src_q == rss_pkg::SRC_SYNTH && arm_q &&
    (pst_q == P_IDLE || pst_q == P_DONE);
  assign active = pst_q != P_IDLE && pst_q != P_DONE && pst_q != P_STOP;
  assign wa = seq_tab_q[seq_idx_q];
  assign last_slice = slice_ptr_q + 10'h2 >= wave_end_q;
  assign {wrap, phase_n} = {1'b0, phase_q} + {1'b0, 24'(freq_q * rss_pkg::PHASE_STEP)};

  always_comb
  begin
    scaled = 28'(amp_q);
    // linear envelope over the ramp time
    if (pst_q == P_RISE && ramp_len_q != 16'h0)
      scaled = 28'(amp_q) * 28'(ramp_cnt_q) / 28'(ramp_len_q);
    else if (pst_q == P_FALL && ramp_len_q != 16'h0)
      scaled = 28'(amp_q) * 28'(ramp_len_q - ramp_cnt_q) / 28'(ramp_len_q);
    env = scaled[11:0];
    sine = rss_pkg::SINE_LUT[phase_q[23] ? ~phase_q[22:19] : phase_q[22:19]];
    // code scales linearly, full code is full voltage
    prod = env * sine;
    sample_d = prod[19:8];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pst_q <= P_IDLE;
      oe_d_q <= 1'b0;
      seq_idx_q <= 4'h0;
      wave_start_q <= 10'h0;
      wave_end_q <= 10'h0;
      rep_left_q <= 16'h0;
      slice_ptr_q <= 10'h0;
      amp_q <= 12'h0;
      cyc_left_q <= 8'h0;
      freq_q <= 8'h0;
      fall_q <= 4'h0;
      ramp_len_q <= 16'h0;
      ramp_cnt_q <= 16'h0;
      phase_q <= 24'h0;
      sample_q <= 12'h0;
      sample_tick_q <= 1'b0;
      playing_q <= 1'b0;
      drained_q <= 1'b0;
    end
    else
    begin
      oe_d_q <= oe_q;
      sample_tick_q <= tick;
      unique case (pst_q)
        P_IDLE, P_DONE:
        begin
          sample_q <= 12'h0;
          if (start_go)
          begin
            seq_idx_q <= ss_start_q;
            drained_q <= 1'b0;
            playing_q <= 1'b1;
            pst_q <= P_WAVE;
          end
        end
        P_WAVE:
        begin
          wave_start_q <= ram_q[wa][9:0];
          slice_ptr_q <= ram_q[wa][9:0];
          wave_end_q <= ram_q[wa + 10'h1][9:0];
          rep_left_q <= (ram_q[wa + 10'h2] == 16'h0) ? 16'h1 : ram_q[wa + 10'h2];
          pst_q <= P_SLICE;
        end
        P_SLICE:
        begin
          amp_q <= ram_q[slice_ptr_q][11:0];
          cyc_left_q <= ram_q[slice_ptr_q + 10'h1][rss_pkg::CYC_LSB +: 8];
          freq_q <= ram_q[slice_ptr_q + 10'h1][7:0];
          ramp_len_q <= ramp_len(ram_q[slice_ptr_q + 10'h2][rss_pkg::RISE_LSB +: 4]);
          fall_q <= ram_q[slice_ptr_q + 10'h2][3:0];
          ramp_cnt_q <= 16'h0;
          phase_q <= 24'h0;
          pst_q <= P_RISE;
        end
        P_RISE, P_SINE, P_FALL:
        begin
          if (tick)
          begin
            sample_q <= sample_d;
            phase_q <= phase_n;
            ramp_cnt_q <= ramp_cnt_q + 16'h1;
            if ((pst_q == P_RISE && ramp_cnt_q >= ramp_len_q && cyc_left_q == 8'h0) ||
              (pst_q == P_SINE && wrap && cyc_left_q <= 8'h1))
            begin
              ramp_len_q <= ramp_len(fall_q);
              ramp_cnt_q <= 16'h0;
              pst_q <= P_FALL;
            end
            else if (pst_q == P_RISE && ramp_cnt_q >= ramp_len_q)
            begin
              // restart phase: whole periods, at the cost of a step
              pst_q <= P_SINE;
              phase_q <= 24'h0;
            end
            else if (pst_q == P_SINE && wrap)
              cyc_left_q <= cyc_left_q - 8'h1;
            else if (pst_q == P_FALL && ramp_cnt_q >= ramp_len_q)
            begin
              pst_q <= P_SLICE;
              if (!last_slice)
                slice_ptr_q <= slice_ptr_q + 10'h3;
              else if (rep_left_q > 16'h1)
              begin
                rep_left_q <= rep_left_q - 16'h1;
                slice_ptr_q <= wave_start_q;
              end
              else if (seq_idx_q == ss_end_q || seq_idx_q == rss_pkg::SEQ_LAST)
              begin
                drained_q <= 1'b1;
                playing_q <= 1'b0;
                pst_q <= P_DONE;
              end
              else
              begin
                seq_idx_q <= seq_idx_q + 4'h1;
                pst_q <= P_WAVE;
              end
            end
          end
        end
        P_STOP:
        begin
          // walk the output down rather than cut it
          if (tick)
          begin
            if (sample_q <= rss_pkg::STOP_STEP)
            begin
              sample_q <= 12'h0;
              drained_q <= 1'b1;
              playing_q <= 1'b0;
              pst_q <= P_DONE;
            end
            else
              sample_q <= sample_q - rss_pkg::STOP_STEP;
          end
        end
      endcase
      if (active && !oe_q)
        pst_q <= P_STOP;
    end
  end
endmodule
`default_nettype wire

// ### dv/rss_sva.sv
// link timing checks between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module rss_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] rise_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // link clock rises counted per frame
  always_ff @(posedge clk)
  begin
    if (!rst_b || cs_b)
      rise_q <= 5'h00;
    else if (sclk && !$past(sclk))
      rise_q <= rise_q + 5'h01;
  end
  sclk_idle_a: assert property (cs_b |-> !sclk)
    else $error("link clock moves outside a frame");
  sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high half wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("link clock low half too short");
  lead_in_a: assert property ($fell(cs_b) |-> !sclk[*8])
    else $error("link clock rises too soon after select");
  word_bits_a: assert property ($rose(cs_b) |-> rise_q == 5'h10)
    else $error("frame does not carry sixteen bits");
  frame_len_a: assert property ($fell(cs_b) |-> ##[136:152] $rose(cs_b))
    else $error("frame length out of range");
  // data must not move while the device may sample it
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("host data changed while clock high");
  frame_gap_a: assert property ($rose(cs_b) |-> cs_b[*3])
    else $error("frames too close together");
  cover property ($rose(cs_b));
  cover property (!cs_b && miso);
  cover property ($rose(sclk) && mosi);
endmodule
`default_nettype wire

// ### dv/tb_ram_sine_synthesis_sequencer.sv
// top bench: host and device ends joined by the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_ram_sine_synthesis_sequencer;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er, watch;
  logic [7:0] paddr, fr, up;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] sample_q, amp, peak, prev;
  logic [3:0] k;
  logic sample_tick_q, playing_q, drained_q;
  int n_mismatch = 0, check_count = 0, cyc = 0, ticks = 0;
  int n [4];
  rss_link_if link ();
  rss_host rss_host_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  rss_dev #(.SAMPLE_DIV(20)) rss_dev_inst (.clk(clk), .rst_b(rst_b), .link(link),
    .sample_q(sample_q), .sample_tick_q(sample_tick_q), .playing_q(playing_q),
    .drained_q(drained_q));
  rss_sva rss_sva_inst (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    check(32'(got >= exp - tol && got <= exp + tol), 32'h1);
  endtask
  // one rise tick, one sine period at 3.9 hz per code, one fall tick
  function automatic int slice_ticks(input int f);
    return int'(rss_pkg::SAMPLE_RATE_HZ * 1000 / (rss_pkg::FREQ_STEP_MHZ * f)) + 2;
  endfunction
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // tick count and peak while playing, stop ramp watch, timeout
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prev <= sample_q;
    if (playing_q && sample_tick_q)
      ticks <= ticks + 1;
    if (playing_q && sample_tick_q && sample_q > peak)
      peak <= sample_q;
    // stop ramp never falls faster than one step a tick
    if (watch && sample_tick_q)
      check(32'({1'b0, prev} > {1'b0, sample_q} + 13'h0010), 32'h0);
    if (cyc == 100000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle();
    do apb(1'b0, rss_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  // bit 16 marks a main-map word; the host adds the long gap
  task automatic send(input logic [16:0] w);
    idle();
    apb(1'b1, rss_pkg::REG_TX, {15'h0, w});
  endtask
  task automatic load(input logic [15:0] rep, input logic [7:0] f);
    logic [15:0] w [11];
    // slices contiguous, end at last word
    w = '{rss_pkg::CMD_BURST_WRITE, 16'h0000, 16'h0003, 16'h0100, 16'h0102, rep,
      rss_pkg::CMD_SYNTH_WRITE, 16'h0100, {4'h0, amp}, {8'h01, f}, {8'h00, up}};
    send(17'h18007);
    foreach (w[i]) send({1'b0, w[i]});
  endtask
  task automatic arm(input logic [15:0] ss);
    send(17'h18007);
    send({1'b0, rss_pkg::CMD_START_STOP});
    send({1'b0, ss});
    ticks <= 0;
    peak <= 12'h000;
    send(17'h15010);
  endtask
  task automatic play(input logic [15:0] ss, output int t);
    arm(ss);
    wait (playing_q === 1'b1);
    wait (drained_q === 1'b1);
    repeat (2) @(posedge clk);
    t = ticks;
    check(32'(sample_q), 32'h0);
    send(17'h15000);
  endtask
  initial
  begin
    {rst_b, psel, penable, pwrite, watch} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hcde1));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    check(32'(er), 32'h1);
    apb(1'b1, rss_pkg::REG_STATUS, 32'h1);
    check(32'(er), 32'h1);
    $display("done: refusals");
    send(17'h19600);
    amp = 12'($urandom_range(4095, 1024));
    fr = 8'($urandom_range(48, 32));
    up = 8'h00;
    load(16'h0000, fr);
    send({1'b0, rss_pkg::CMD_SEQUENCE});
    repeat (15) send(17'h00000);
    play(16'h0000, n[0]);
    near(n[0], slice_ticks(fr), 2);
    check(32'(peak != 12'h000 && peak <= amp), 32'h1);
    send(17'h10000);
    idle();
    apb(1'b0, rss_pkg::REG_RX, 32'h0);
    check(rd & 32'hffff, 32'h1 << rss_pkg::COND_DRAINED_BIT);
    $display("done: single wave");
    load(16'h0001, fr);
    play(16'h0000, n[1]);
    near(n[1], n[0], 2);
    load(16'h0002, fr);
    play(16'h0000, n[2]);
    near(n[2], 2 * n[1], 4);
    send(17'h15010);
    repeat (2000) @(posedge clk);
    check(32'(playing_q), 32'h0);
    send(17'h15000);
    $display("done: repeats");
    load(16'h0001, fr);
    k = 4'($urandom_range(14, 0));
    play({k, k, 8'h00}, n[3]);
    near(n[3], n[1], 2);
    play(16'he000, n[3]);
    near(n[3], 15 * n[1], 30);
    $display("done: sequence range");
    up = 8'h10;
    load(16'h0001, fr);
    play(16'h0000, n[3]);
    near(n[3] - n[1], rss_pkg::RAMP_SHORT_SMP, 2);
    $display("done: ramp");
    // slow sine, so only the stop ramp could fall fast
    up = 8'h00;
    load(16'h0001, 8'h01);
    arm(16'h0000);
    repeat (12000) @(posedge clk);
    watch <= 1'b1;
    send(17'h15000);
    idle();
    check(32'(playing_q), 32'h1);
    wait (drained_q === 1'b1);
    @(posedge clk);
    watch <= 1'b0;
    check(32'(sample_q), 32'h0);
    $display("done: abort");
    test_done();
  end
endmodule
`default_nettype wire
